// >>> logic/error_and_arith_control_regs.sv
`include "err_arith_defines.svh"
module error_and_arith_control_regs (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_ce,
   // Register move port on the main exchange
   input wire logic i_move_wr,
   input wire logic i_move_rd,
   input wire logic [3:0] i_move_sel,
   input wire logic [23:0] i_main_exchange,
   output logic [23:0] o_main_exchange,
   // Processor state
   input wire logic i_running,
   input wire logic i_start,
   input wire logic i_load,
   input wire logic i_memory_mode,
   input wire logic i_cache_source,
   input wire logic i_tape_mode,
   // Cache lookup
   input wire logic i_fetch,
   input wire logic i_hit_a,
   input wire logic i_hit_b,
   input wire logic [23:0] i_micro_a,
   input wire logic [23:0] i_micro_b,
   input wire logic [9:0] i_key_a,
   input wire logic [9:0] i_key_b,
   input wire logic i_micro_load,
   input wire logic i_micro_parity_bad,
   input wire logic i_cassette_bad_pin,
   // Memory
   input wire logic i_mem_micro,
   input wire logic i_mem_access,
   input wire logic [23:0] i_mem_addr,
   input wire logic [23:0] i_memory_size_limit,
   input wire logic [23:0] i_installed_memory,
   input wire logic i_mem_read_proc,
   input wire logic i_err_corrected,
   input wire logic i_err_uncorr_other,
   input wire logic i_err_uncorr_proc,
   input wire logic i_log_read,
   input wire logic [15:0] i_len_field_register,
   // Arithmetic unit
   input wire logic i_carry_valid,
   input wire logic i_carry,
   input wire logic [2:0] i_cond_c_set,
   input wire logic [2:0] i_cond_d_set,
   output logic [23:0] o_micro,
   output logic o_halt,
   output logic [4:0] o_eff_length,
   output logic [4:0] o_mem_length,
   output logic o_bcd_mode,
   output logic [1:0] o_log_level
);
   logic [3:0] processor_parity_errors;
   logic [3:0] memory_error_flags;
   logic [3:0] general_nibble_a;
   logic [3:0] general_nibble_b;
   logic [3:0] condition_nibble_c;
   logic [3:0] condition_nibble_d;
   logic [7:0] arith_control;
   logic [7:0] tcount;
   logic cassette_bad;
   logic timeout_hit;
   err_arith_pkg::log_level_t log_level;
   logic log_changed;

   function automatic logic [4:0] clamp_len(input logic [4:0] v);
      clamp_len = (v > `MAX_FIELD_LEN) ? `MAX_FIELD_LEN : v;
   endfunction

   function automatic logic key_bad(input logic [9:0] k);
      key_bad = ~(^k);
   endfunction

   pin_sync3 cassette_sync (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .i_pin(i_cassette_bad_pin),
      .o_level(cassette_bad)
   );

   error_log log_unit (
      .i_mclk(i_mclk),
      .i_rst(i_rst),
      .i_ce(i_ce),
      .i_corrected(i_err_corrected),
      .i_uncorr_other(i_err_uncorr_other),
      .i_uncorr_proc(i_err_uncorr_proc),
      .i_read_clear(i_log_read),
      .o_level(log_level),
      .o_changed(log_changed)
   );

   wire double_hit = i_fetch & i_hit_a & i_hit_b;
   wire key_fail = i_fetch & (key_bad(i_key_a) | key_bad(i_key_b));
   wire micro_fail = i_micro_load & i_micro_parity_bad;
   wire halt_dh = double_hit & i_cache_source;
   wire halt_key = key_fail & i_cache_source;
   wire halt_cas = cassette_bad & i_tape_mode;
   wire halt_now = halt_dh | halt_key | micro_fail | halt_cas;
   wire flag_proc = (double_hit | key_fail) & ~i_cache_source;
   wire out_of_bounds = i_mem_access &
      ((i_mem_addr >= i_memory_size_limit) |
       (i_mem_addr >= i_installed_memory));
   wire uncorr_read = i_mem_read_proc & i_err_uncorr_proc;
   wire [3:0] mem_set = {timeout_hit, out_of_bounds, log_changed,
      uncorr_read};
   wire flag_mem = (|mem_set) & i_running;
   wire [3:0] proc_set = {double_hit, key_fail, micro_fail, cassette_bad};
   wire proc_clear = i_start | (i_load & i_memory_mode & ~i_running);
   wire wr_pe = i_move_wr & (i_move_sel == `SEL_PROC_ERR);
   wire wr_me = i_move_wr & (i_move_sel == `SEL_MEM_ERR);
   wire wr_a = i_move_wr & (i_move_sel == `SEL_NIB_A);
   wire wr_b = i_move_wr & (i_move_sel == `SEL_NIB_B);
   wire wr_c = i_move_wr & (i_move_sel == `SEL_NIB_C);
   wire wr_d = i_move_wr & (i_move_sel == `SEL_NIB_D);
   wire wr_cp = i_move_wr & (i_move_sel == `SEL_ARITH);
   wire wr_mu = i_move_wr & (i_move_sel == `SEL_MODE_UNIT);
   wire [3:0] flag_d = {flag_proc | flag_mem, i_cond_d_set};
   wire [4:0] field_len = arith_control[`LEN_MSB:0];
   wire [1:0] mode_bits = arith_control[6:`MODE_LSB];
   wire [3:0] wdat = i_main_exchange[3:0];
   wire [4:0] eff_len = clamp_len(field_len);
   wire [4:0] mem_len = (i_len_field_register == 16'h0000) ? eff_len :
      ((i_len_field_register > 16'h0018) ? `MAX_FIELD_LEN :
       i_len_field_register[4:0]);
   wire [23:0] rd_mux =
      (i_move_sel == `SEL_PROC_ERR) ? {20'h00000, processor_parity_errors} :
      (i_move_sel == `SEL_MEM_ERR) ? {20'h00000, memory_error_flags} :
      (i_move_sel == `SEL_NIB_A) ? {20'h00000, general_nibble_a} :
      (i_move_sel == `SEL_NIB_B) ? {20'h00000, general_nibble_b} :
      (i_move_sel == `SEL_NIB_C) ? {20'h00000, condition_nibble_c} :
      (i_move_sel == `SEL_NIB_D) ? {20'h00000, condition_nibble_d} :
      (i_move_sel == `SEL_ARITH) ? {16'h0000, arith_control} :
      (i_move_sel == `SEL_MODE_UNIT) ? {22'h000000, mode_bits} :
      24'h000000;
   wire [23:0] next_micro = i_hit_a ?
      (i_hit_b ? (i_micro_a | i_micro_b) : i_micro_a) : i_micro_b;

   // Memory micro time limit
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         tcount <= 8'h00;
         timeout_hit <= 1'b0;
      end else if (i_ce) begin
         timeout_hit <= 1'b0;
         if (!i_mem_micro) begin
            tcount <= 8'h00;
         end else if (tcount == 8'(`TIMEOUT_CYC - 1)) begin
            timeout_hit <= 1'b1;
            tcount <= 8'h00;
         end else begin
            tcount <= tcount + 8'h01;
         end
      end
   end

   // Error registers: sets win over clears
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         processor_parity_errors <= `RST_NIBBLE;
         memory_error_flags <= `RST_NIBBLE;
      end else if (i_ce) begin
         if (wr_pe) begin
            processor_parity_errors <= wdat | proc_set;
         end else if (proc_clear) begin
            processor_parity_errors <= proc_set;
         end else begin
            processor_parity_errors <= processor_parity_errors |
               proc_set;
         end
         if (wr_me) begin
            memory_error_flags <= wdat | mem_set;
         end else begin
            memory_error_flags <= memory_error_flags | mem_set;
         end
      end
   end

   // Nibbles and arithmetic control
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         general_nibble_a <= `RST_NIBBLE;
         general_nibble_b <= `RST_NIBBLE;
         condition_nibble_c <= `RST_NIBBLE;
         condition_nibble_d <= `RST_NIBBLE;
         arith_control <= `RST_ARITH;
      end else if (i_ce) begin
         if (wr_a) general_nibble_a <= wdat;
         if (wr_b) general_nibble_b <= wdat;
         condition_nibble_c <= (wr_c ? wdat : condition_nibble_c) |
            {1'b0, i_cond_c_set};
         condition_nibble_d <= (wr_d ? wdat : condition_nibble_d) |
            flag_d;
         if (wr_cp) begin
            arith_control <= i_main_exchange[7:0];
         end else if (wr_mu) begin
            arith_control[6:`MODE_LSB] <= wdat[1:0];
         end else if (i_carry_valid) begin
            arith_control[`BIT_CARRY] <= i_carry;
         end
      end
   end

   // Registered outputs
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_main_exchange <= 24'h000000;
         o_micro <= 24'h000000;
         o_halt <= 1'b0;
         o_eff_length <= 5'h00;
         o_mem_length <= 5'h00;
         o_bcd_mode <= 1'b0;
         o_log_level <= 2'h0;
      end else if (i_ce) begin
         if (i_move_rd) o_main_exchange <= rd_mux;
         if (i_fetch) o_micro <= next_micro;
         if (i_start) begin
            o_halt <= 1'b0;
         end else if (halt_now) begin
            o_halt <= 1'b1;
         end
         o_eff_length <= eff_len;
         o_mem_length <= mem_len;
         o_bcd_mode <= mode_bits[0];
         o_log_level <= log_level;
      end
   end
endmodule

// >>> logic/err_arith_defines.svh
`ifndef ERR_ARITH_DEFINES_SVH
`define ERR_ARITH_DEFINES_SVH
// Register select codes on the move port
`define SEL_PROC_ERR 4'h0
`define SEL_MEM_ERR 4'h1
`define SEL_NIB_A 4'h2
`define SEL_NIB_B 4'h3
`define SEL_NIB_C 4'h4
`define SEL_NIB_D 4'h5
`define SEL_ARITH 4'h6
`define SEL_MODE_UNIT 4'h7
// Field positions
`define BIT_DOUBLE_HIT 3
`define BIT_KEY_PARITY 2
`define BIT_MICRO_PARITY 1
`define BIT_CASSETTE 0
`define BIT_MEM_TIMEOUT 3
`define BIT_OUT_OF_BOUNDS 2
`define BIT_LOG_CHANGE 1
`define BIT_UNCORR_READ 0
`define BIT_ERROR_FLAG 3
`define BIT_CARRY 7
`define MODE_LSB 5
`define LEN_MSB 4
// Reset values and limits
`define RST_NIBBLE 4'h0
`define RST_ARITH 8'h00
`define MAX_FIELD_LEN 5'h18
`define TIMEOUT_NS 1000
`define CLK_NS 40
`define TIMEOUT_CYC ((`TIMEOUT_NS) / (`CLK_NS))
`endif

// >>> logic/err_arith_pkg.sv
package err_arith_pkg;
   typedef enum logic [1:0] {
      log_none,
      log_corrected,
      log_uncorr_other,
      log_uncorr_proc
   } log_level_t;
   typedef enum logic {
      mode_binary,
      mode_bcd
   } arith_mode_t;
endpackage

// >>> logic/pin_sync3.sv
module pin_sync3 (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_pin,
   output logic o_level
);
   logic s1;
   logic s2;
   logic s3;
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
         o_level <= 1'b0;
      end else if (i_ce) begin
         s1 <= i_pin;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            o_level <= s3;
         end
      end
   end
endmodule

// >>> logic/error_log.sv
module error_log (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_corrected,
   input wire logic i_uncorr_other,
   input wire logic i_uncorr_proc,
   input wire logic i_read_clear,
   output err_arith_pkg::log_level_t o_level,
   output logic o_changed
);
   err_arith_pkg::log_level_t event_level;
   logic take;
   assign event_level = i_uncorr_proc ? err_arith_pkg::log_uncorr_proc :
      i_uncorr_other ? err_arith_pkg::log_uncorr_other :
      i_corrected ? err_arith_pkg::log_corrected : err_arith_pkg::log_none;
   // First error, or a higher one, replaces contents
   assign take = (event_level != err_arith_pkg::log_none) &&
      (event_level > o_level);
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_level <= err_arith_pkg::log_none;
         o_changed <= 1'b0;
      end else if (i_ce) begin
         o_changed <= take;
         if (take) begin
            o_level <= event_level;
         end else if (i_read_clear) begin
            o_level <= err_arith_pkg::log_none;
         end
      end
   end
endmodule

// >>> bench/err_arith_monitor.sv
module err_arith_monitor (
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_ce,
   input wire logic i_move_wr,
   input wire logic i_move_rd,
   input wire logic [3:0] i_move_sel,
   input wire logic [23:0] i_main_exchange,
   input wire logic [23:0] o_main_exchange,
   input wire logic i_start,
   input wire logic i_cache_source,
   input wire logic i_fetch,
   input wire logic i_hit_a,
   input wire logic i_hit_b,
   input wire logic i_micro_load,
   input wire logic i_micro_parity_bad,
   input wire logic i_err_uncorr_proc,
   input wire logic o_halt,
   input wire logic [4:0] o_eff_length,
   input wire logic o_bcd_mode,
   input wire logic [1:0] o_log_level
);
   wire logic [4:0] wr_len = i_main_exchange[4:0];
   wire logic wr_mode = i_main_exchange[5];
   default clocking @(posedge i_mclk);
   endclocking
   default disable iff (i_rst || !i_ce);
   sequence s_dhit;
      i_fetch && i_hit_a && i_hit_b;
   endsequence
   sequence s_wr_cp;
      i_move_wr && i_move_sel == 4'h6 && wr_len != 5'h00 ##1 i_ce;
   endsequence
   chk_dhit_halt: assert property (
      s_dhit ##0 (i_cache_source && !i_start) |=> o_halt)
      else $error("no halt after double hit");
   chk_parity_halt: assert property (
      i_micro_load && i_micro_parity_bad && !i_start |=> o_halt)
      else $error("no halt after micro parity fault");
   chk_halt_hold: assert property (
      o_halt && !i_start |=> o_halt)
      else $error("halt dropped without start");
   chk_len_clamp: assert property (
      s_wr_cp |=> o_eff_length == (($past(wr_len, 2) > 5'h18) ?
      5'h18 : $past(wr_len, 2)))
      else $error("field length not clamped");
   chk_mode_write: assert property (
      s_wr_cp |=> o_bcd_mode == $past(wr_mode, 2))
      else $error("mode bit not taken");
   chk_unit_read: assert property (
      i_move_rd && i_move_sel == 4'h7 |=> o_main_exchange[23:2] == 22'h0)
      else $error("mode unit upper bits set");
   chk_cp_read: assert property (
      i_move_rd && i_move_sel == 4'h6 |=> o_main_exchange[23:8] == 16'h0)
      else $error("arith control upper bits set");
   chk_log_top: assert property (
      i_err_uncorr_proc |-> ##[1:2] o_log_level == 2'h3)
      else $error("log level not highest");
endmodule

bind error_and_arith_control_regs err_arith_monitor i_mon (
   .i_mclk, .i_rst, .i_ce, .i_move_wr, .i_move_rd, .i_move_sel,
   .i_main_exchange, .o_main_exchange, .i_start, .i_cache_source,
   .i_fetch, .i_hit_a, .i_hit_b, .i_micro_load, .i_micro_parity_bad,
   .i_err_uncorr_proc, .o_halt, .o_eff_length, .o_bcd_mode, .o_log_level);

// >>> bench/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_mclk = 0, i_rst = 1, i_ce = 1, i_running = 1, i_start = 0;
   logic i_move_wr = 0, i_move_rd = 0, i_load = 0, i_memory_mode = 1;
   logic i_cache_source = 0, i_tape_mode = 0, i_fetch = 0, i_hit_a = 0;
   logic i_hit_b = 0, i_micro_load = 0, i_micro_parity_bad = 0;
   logic i_cassette_bad_pin = 0, i_mem_micro = 0, i_mem_access = 0;
   logic i_mem_read_proc = 0, i_err_corrected = 0, i_err_uncorr_other = 0;
   logic i_err_uncorr_proc = 0, i_log_read = 0, i_carry_valid = 0;
   logic i_carry = 0, o_halt, o_bcd_mode;
   logic [3:0] i_move_sel = 0;
   logic [9:0] i_key_a = 1, i_key_b = 1;
   logic [2:0] i_cond_c_set = 0, i_cond_d_set = 0, t;
   logic [15:0] i_len_field_register = 0;
   logic [23:0] i_main_exchange = 0, i_micro_a = 0, i_micro_b = 0, d;
   logic [23:0] i_mem_addr = 0, i_memory_size_limit = 0;
   logic [23:0] i_installed_memory = 24'h2000, o_main_exchange, o_micro;
   logic [4:0] o_eff_length, o_mem_length, e;
   logic [1:0] o_log_level;
   logic [23:0] m [0:15];
   logic [7:0] cp [0:3] = '{8'h39, 8'h7F, 8'h58, 8'h01};
   logic [9:0] fe [0:3] = '{10'h003, 10'h001, 10'h00C, 10'h008};
   logic [23:0] ad [0:2] = '{24'h0FFF, 24'h1000, 24'h2000};
   int miscompares = 0, checked = 0, seed = 32'h673e93f1, s, n;
   error_and_arith_control_regs i_error_and_arith_control_regs (
      .i_mclk, .i_rst, .i_ce, .i_move_wr, .i_move_rd, .i_move_sel,
      .i_main_exchange, .o_main_exchange, .i_running, .i_start, .i_load,
      .i_memory_mode, .i_cache_source, .i_tape_mode, .i_fetch, .i_hit_a,
      .i_hit_b, .i_micro_a, .i_micro_b, .i_key_a, .i_key_b, .i_micro_load,
      .i_micro_parity_bad, .i_cassette_bad_pin, .i_mem_micro, .i_mem_access,
      .i_mem_addr, .i_memory_size_limit, .i_installed_memory,
      .i_mem_read_proc, .i_err_corrected, .i_err_uncorr_other,
      .i_err_uncorr_proc, .i_log_read, .i_len_field_register, .i_carry_valid,
      .i_carry, .i_cond_c_set, .i_cond_d_set, .o_micro, .o_halt,
      .o_eff_length, .o_mem_length, .o_bcd_mode, .o_log_level);
   initial forever #20 i_mclk = ~i_mclk;
   task chk(input logic [23:0] got, input logic [23:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task stop_test;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task wr(input logic [3:0] sl, input logic [23:0] dv);
      @(posedge i_mclk);
      i_move_wr <= 1;
      i_move_sel <= sl;
      i_main_exchange <= dv;
      @(posedge i_mclk);
      i_move_wr <= 0;
      if (sl < 6) m[sl] = {20'h0, dv[3:0]};
      if (sl == 6) m[6] = {16'h0, dv[7:0]};
      if (sl == 6) m[7] = {22'h0, dv[6:5]};
      if (sl == 7) m[7] = {22'h0, dv[1:0]};
      if (sl == 7) m[6][6:5] = dv[1:0];
   endtask
   task rd(input logic [3:0] sl, input logic [23:0] ex);
      @(posedge i_mclk);
      i_move_rd <= 1;
      i_move_sel <= sl;
      @(posedge i_mclk);
      i_move_rd <= 0;
      #1 chk(o_main_exchange, ex);
   endtask
   // One-cycle event pulses
   task ev(input logic [9:0] v);
      @(posedge i_mclk);
      {i_load, i_start, i_log_read, i_err_uncorr_proc, i_err_uncorr_other,
         i_err_corrected, i_micro_parity_bad, i_micro_load, i_hit_b,
         i_fetch} <= v;
      i_hit_a <= v[1];
      i_mem_read_proc <= v[6];
      @(posedge i_mclk);
      {i_load, i_start, i_log_read, i_err_uncorr_proc, i_err_uncorr_other,
         i_err_corrected, i_micro_parity_bad, i_micro_load, i_hit_b,
         i_fetch, i_hit_a, i_mem_read_proc} <= 12'h000;
      #1;
   endtask
   initial begin
      foreach (m[i]) m[i] = 0;
      repeat (3) @(posedge i_mclk);
      i_rst <= 0;
      for (s = 0; s < 10; s++) rd(4'(s), 24'h0);
      repeat (24) begin
         s = 2 + $unsigned($random(seed)) % 8;
         wr(4'(s), 24'($random(seed)));
         rd(4'(s), m[s]);
         rd(4'h7, m[7]);
      end
      for (n = 0; n < 4; n++) begin
         wr(4'h6, {16'h0, cp[n]});
         e = (cp[n][4:0] > 5'h18) ? 5'h18 : cp[n][4:0];
         @(posedge i_mclk);
         #1 chk({19'h0, o_eff_length}, {19'h0, e});
         chk({19'h0, o_mem_length}, {19'h0, e});
         chk({23'h0, o_bcd_mode}, {23'h0, cp[n][5]});
      end
      @(posedge i_mclk);
      i_len_field_register <= 16'h0005;
      i_carry_valid <= 1;
      i_carry <= 1;
      @(posedge i_mclk);
      i_carry_valid <= 0;
      m[6][7] = 1;
      @(posedge i_mclk);
      #1 chk({19'h0, o_mem_length}, 24'h5);
      rd(4'h6, m[6]);
      wr(4'h4, 24'h8);
      @(posedge i_mclk);
      i_cond_c_set <= 3'h5;
      @(posedge i_mclk);
      i_cond_c_set <= 3'h0;
      rd(4'h4, 24'hD);
      for (n = 0; n < 8; n++) begin
         t = 3'(n);
         wr(4'h5, 24'h0);
         i_cache_source <= t[2];
         i_key_a <= (t == 3'h1) ? 10'h003 : 10'h001;
         i_key_b <= (t == 3'h5) ? 10'h003 : 10'h001;
         i_micro_a <= 24'($random(seed));
         i_micro_b <= 24'($random(seed));
         ev(fe[t[1:0]]);
         chk({23'h0, o_halt}, {23'h0, t[1:0] == 2 || t == 4 || t == 5});
         if (t[1:0] == 0) chk(o_micro, i_micro_a | i_micro_b);
         rd(4'h0, (t[1:0] == 3) ? 24'h0 : 24'h8 >> t[1:0]);
         if (t == 0 || t == 1) rd(4'h5, 24'h8);
         if (t == 3) rd(4'h5, 24'h0);
         if (t[1:0] == 2) begin
            @(posedge i_mclk);
            i_running <= 1'b0;
            ev(10'h200);
            @(posedge i_mclk);
            i_running <= 1'b1;
         end
         if (t[1:0] == 2) rd(4'h0, 24'h0);
         ev(10'h100);
         chk({23'h0, o_halt}, 24'h0);
      end
      for (n = 0; n < 2; n++) begin
         @(posedge i_mclk);
         i_tape_mode <= (n == 1);
         i_cassette_bad_pin <= 1;
         repeat (6) @(posedge i_mclk);
         i_cassette_bad_pin <= 0;
         for (s = 0; s < 20 && o_halt !== 1'b1; s++) @(posedge i_mclk) #1;
         if (n == 1 && s == 20) miscompares++;
         if (n == 1 && s == 20) stop_test;
         #1 chk({23'h0, o_halt}, 24'(n));
         rd(4'h0, 24'h1);
         ev(10'h100);
      end
      for (n = 0; n < 2; n++) begin
         @(posedge i_mclk);
         i_mem_micro <= 1;
         repeat (n ? 30 : 20) @(posedge i_mclk);
         i_mem_micro <= 0;
         rd(4'h1, n ? 24'h8 : 24'h0);
      end
      chk({23'h0, o_halt}, 24'h0);
      rd(4'h5, 24'h8);
      for (n = 0; n < 3; n++) begin
         wr(4'h1, 24'h0);
         i_mem_access <= 1;
         i_mem_addr <= ad[n];
         i_memory_size_limit <= (n == 2) ? 24'h3000 : 24'h1000;
         @(posedge i_mclk);
         i_mem_access <= 0;
         rd(4'h1, n ? 24'h4 : 24'h0);
      end
      wr(4'h1, 24'h0);
      for (n = 0; n < 5; n++) begin
         ev(10'h010 << n % 3 + n / 3 * 2);
         @(posedge i_mclk);
         e = (n < 3) ? 5'(n + 1) : 5'(n % 4);
         #1 chk({22'h0, o_log_level}, {19'h0, e});
      end
      rd(4'h1, 24'h3);
      d = m[2];
      @(posedge i_mclk);
      i_ce <= 1'b0;
      wr(4'h2, ~d);
      i_ce <= 1'b1;
      m[2] = d;
      rd(4'h2, d);
      stop_test;
   end
endmodule
